// ### rtl/lpa_consts.svh
`ifndef LPA_CONSTS_SVH
`define LPA_CONSTS_SVH

// register indices; byte address is four times the index
`define LPA_IDX_CTRL1     4'h0
`define LPA_IDX_CTRL2     4'h1
`define LPA_IDX_DATA_LO   4'h2
`define LPA_IDX_DATA_HI   4'h3
`define LPA_IDX_THLO_LO   4'h4
`define LPA_IDX_THLO_HI   4'h5
`define LPA_IDX_THHI_LO   4'h6
`define LPA_IDX_THHI_HI   4'h7
`define LPA_IDX_TEST      4'h8
`define LPA_IDX_OSC       4'h9
`define LPA_IDX_STATUS    4'ha

// first control word fields
`define LPA_C1_RUN        7
`define LPA_C1_SRC_HI     6
`define LPA_C1_SRC_LO     5
`define LPA_C1_FLAG       2
`define LPA_C1_PERS_HI    1
`define LPA_C1_PERS_LO    0

// reset values
`define LPA_CTRL1_RST     8'h00
`define LPA_CTRL2_RST     8'h00
`define LPA_THLO_RST      16'h0000
`define LPA_THHI_RST      16'hffff

// persistence counts
`define LPA_PERS_N0       5'h01
`define LPA_PERS_N1       5'h04
`define LPA_PERS_N2       5'h08
`define LPA_PERS_N3       5'h10

// timing
`define LPA_CLK_HZ        250000000
`define LPA_MOD_HZ        360000
`define LPA_OSC_REF_KHZ   725
`define LPA_REXT_REF_KOHM 499

`endif

// ### rtl/lpa_pkg.sv
package lpa_pkg;

    typedef enum logic [1:0] {
        LPA_PH_IDLE = 2'b00,
        LPA_PH_VIS  = 2'b01,
        LPA_PH_IR   = 2'b10,
        LPA_PH_PROX = 2'b11
    } lpa_phase_t;

    // second control word layout
    typedef struct packed {
        logic       scheme;
        logic       modulate;
        logic [1:0] current;
        logic [1:0] res;
        logic [1:0] range;
    } lpa_cfg_t;

    typedef struct packed {
        logic [15:0] vis;
        logic [15:0] ir;
        logic [15:0] prox;
    } lpa_result_t;

endpackage : lpa_pkg

// ### rtl/lpa_phase_seq.sv
`include "lpa_consts.svh"

module lpa_phase_seq (
    input  wire logic               osc_clk,    // conversion oscillator
    input  wire logic               sys_rst,    // system reset, other domain
    input  wire logic               run,        // run level, other domain
    input  wire logic [1:0]         res,        // resolution, other domain
    input  wire logic [15:0]        adc_count,  // converter count, osc domain
    output lpa_pkg::lpa_phase_t     phase,      // current phase
    output lpa_pkg::lpa_result_t    result,     // held results of last cycle
    output logic                    done_tgl    // toggles per full cycle
);

    logic [1:0]  rst_sync;
    logic [1:0]  run_sync;
    logic [1:0]  res_s1;
    logic [1:0]  res_s2;
    logic [15:0] cnt_reg;
    logic [15:0] lim_reg;
    logic [15:0] vis_reg;
    logic [15:0] ir_reg;
    wire         rst_o = rst_sync[1];
    wire         last  = (cnt_reg == lim_reg);

    // integration length is 2^n oscillator cycles
    function automatic logic [15:0] int_limit(input logic [1:0] r);
        case (r)
            2'h0:    int_limit = 16'hffff;
            2'h1:    int_limit = 16'h0fff;
            2'h2:    int_limit = 16'h00ff;
            default: int_limit = 16'h000f;
        endcase
    endfunction : int_limit

    always_ff @(posedge osc_clk) begin
        rst_sync <= {rst_sync[0], sys_rst};
        run_sync <= {run_sync[0], run};
        res_s1   <= res;
        res_s2   <= res_s1;
    end

    always_ff @(posedge osc_clk) begin
        if (rst_o) begin
            phase    <= lpa_pkg::LPA_PH_IDLE;
            cnt_reg  <= 16'h0000;
            lim_reg  <= 16'h000f;
            vis_reg  <= 16'h0000;
            ir_reg   <= 16'h0000;
            result   <= '0;
            done_tgl <= 1'b0;
        end else begin
            case (phase)
                lpa_pkg::LPA_PH_IDLE: begin
                    cnt_reg <= 16'h0000;
                    lim_reg <= int_limit(res_s2);
                    if (run_sync[1]) begin
                        phase <= lpa_pkg::LPA_PH_VIS;
                    end
                end
                lpa_pkg::LPA_PH_VIS: begin
                    cnt_reg <= last ? 16'h0000 : cnt_reg + 16'h0001;
                    if (last) begin
                        vis_reg <= adc_count;
                        phase   <= lpa_pkg::LPA_PH_IR;
                    end
                end
                lpa_pkg::LPA_PH_IR: begin
                    cnt_reg <= last ? 16'h0000 : cnt_reg + 16'h0001;
                    if (last) begin
                        ir_reg <= adc_count;
                        phase  <= lpa_pkg::LPA_PH_PROX;
                    end
                end
                lpa_pkg::LPA_PH_PROX: begin
                    cnt_reg <= last ? 16'h0000 : cnt_reg + 16'h0001;
                    if (last) begin
                        result   <= {vis_reg, ir_reg, adc_count};
                        done_tgl <= ~done_tgl;
                        phase    <= lpa_pkg::LPA_PH_IDLE;
                    end
                end
                default: begin
                    phase <= lpa_pkg::LPA_PH_IDLE;
                end
            endcase
        end
    end

endmodule : lpa_phase_seq

// ### rtl/lpa_led_drive.sv
`include "lpa_consts.svh"

module lpa_led_drive #(
    parameter int HALF_PERIOD = `LPA_CLK_HZ / (2 * `LPA_MOD_HZ)
) (
    input  wire logic clk_sys,      // system clock
    input  wire logic sys_rst,      // synchronous reset
    input  wire logic prox_phase,   // proximity phase level, osc domain
    input  wire logic modulate,     // 1: square wave, 0: steady
    output logic      led_on        // led drive enable
);

    localparam logic [9:0] HALF_M1 = 10'(HALF_PERIOD - 1);

    logic [1:0] prox_sync;
    logic [9:0] div_reg;
    logic       sq_reg;
    wire        prox_s = prox_sync[1];

    always_ff @(posedge clk_sys) begin
        prox_sync <= {prox_sync[0], prox_phase};
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !prox_s) begin
            div_reg <= 10'h000;
            sq_reg  <= 1'b1;
        end else if (div_reg == HALF_M1) begin
            div_reg <= 10'h000;
            sq_reg  <= ~sq_reg;
        end else begin
            div_reg <= div_reg + 10'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            led_on <= 1'b0;
        end else begin
            led_on <= prox_s && (modulate ? sq_reg : 1'b1);
        end
    end

endmodule : lpa_led_drive

// ### rtl/lpa_top.sv
`include "lpa_consts.svh"

// Contract
// - armed device flags an alert when data leaves the low/high threshold window.
// - reading register 0x0 clears a pending alert flag and releases the pin.
// - alert pin goes low after persistence-selected consecutive out-of-window results, or on a host write of flag bit 2 in register 0x0.
// - persistence field 00, 01, 10, 11 needs 1, 4, 8, 16 results.
// - proximity led drive is steady or a 360 kHz 50 percent square.
// - modulation bit 0 gives steady drive, 1 gives 360 kHz drive.
// - bits 5 and 4 of register 01h pick one of four led currents.
// - current field 00..11 maps to 12.5, 25, 50, 100 mA.
// - visible, infrared and proximity phases run one after another, never together.
// - led drive is on only in the proximity phase, off otherwise.
// - second scheme subtracts background infrared on chip at half resolution.
// - bit 7 of second control word picks unsigned or signed sign-extended proximity.
// - oscillator frequency is 725 kHz times 499 kohm over the scaling resistor.
module lpa_top #(
    parameter int REXT_KOHM = `LPA_REXT_REF_KOHM
) (
    input  wire logic          clk_sys,           // system clock
    input  wire logic          sys_rst,           // synchronous reset, high
    input  wire logic          osc_clk,           // internal oscillator clock
    input  wire logic [15:0]   adc_count,         // converter count, osc domain
    input  wire logic          wb_cyc_i,          // wishbone cycle
    input  wire logic          wb_stb_i,          // wishbone strobe
    input  wire logic          wb_we_i,           // wishbone write
    input  wire logic [7:0]    wb_adr_i,          // wishbone byte address
    input  wire logic [3:0]    wb_sel_i,          // wishbone byte select
    input  wire logic [31:0]   wb_dat_i,          // wishbone write data
    output logic [31:0]        wb_dat_o,          // wishbone read data
    output logic               wb_ack_o,          // wishbone acknowledge
    output lpa_pkg::lpa_phase_t conv_phase,       // phase for the front end
    output logic               led_drive_output,  // led source enable
    output logic [1:0]         led_current_sel,   // led current level
    output logic [1:0]         adc_res_sel,       // converter resolution
    output logic [1:0]         range_sel,         // full scale range
    output logic               int_n              // alert pin, low active
);

    localparam logic [15:0] OSC_KHZ =
        16'(`LPA_OSC_REF_KHZ * `LPA_REXT_REF_KOHM / REXT_KOHM);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]             ctrl1_reg;
    lpa_pkg::lpa_cfg_t      cfg_reg;
    logic [15:0]            data_reg;
    logic [15:0]            thlo_reg;
    logic [15:0]            thhi_reg;
    logic                   flag_reg;
    logic                   flag_next;
    logic                   armed_reg;
    logic [4:0]             pcnt_reg;
    logic [4:0]             pcnt_next;
    logic [2:0]             tgl_sync;
    logic                   cap_vld_reg;
    lpa_pkg::lpa_result_t   cap_reg;
    lpa_pkg::lpa_result_t   seq_result;
    logic                   seq_tgl;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    function automatic logic [4:0] pers_need(input logic [1:0] p);
        case (p)
            2'h0:    pers_need = `LPA_PERS_N0;
            2'h1:    pers_need = `LPA_PERS_N1;
            2'h2:    pers_need = `LPA_PERS_N2;
            default: pers_need = `LPA_PERS_N3;
        endcase
    endfunction : pers_need

    wire [3:0] idx     = wb_adr_i[5:2];
    wire       in_map  = (wb_adr_i[7:6] == 2'h0) && (wb_adr_i[1:0] == 2'h0);
    wire       req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       wr_b0   = req && wb_we_i && wb_sel_i[0] && in_map;
    wire       rd_acc  = req && !wb_we_i && in_map;
    wire [7:0] wbyte   = wb_dat_i[7:0];
    wire       wr_c1   = wr_b0 && (idx == `LPA_IDX_CTRL1);
    wire       wr_c2   = wr_b0 && (idx == `LPA_IDX_CTRL2);
    wire       wr_tll  = wr_b0 && (idx == `LPA_IDX_THLO_LO);
    wire       wr_tlh  = wr_b0 && (idx == `LPA_IDX_THLO_HI);
    wire       wr_thl  = wr_b0 && (idx == `LPA_IDX_THHI_LO);
    wire       wr_thh  = wr_b0 && (idx == `LPA_IDX_THHI_HI);
    wire       rd_c1   = rd_acc && (idx == `LPA_IDX_CTRL1);

    wire [7:0] c1_view = {ctrl1_reg[7:3], flag_reg, ctrl1_reg[1:0]};
    wire [7:0] status  = {1'b0, tgl_sync[2], pcnt_reg, armed_reg};

    wire [15:0] rd_val =
        (idx == `LPA_IDX_CTRL1)   ? {8'h00, c1_view} :
        (idx == `LPA_IDX_CTRL2)   ? {8'h00, cfg_reg} :
        (idx == `LPA_IDX_DATA_LO) ? {8'h00, data_reg[7:0]} :
        (idx == `LPA_IDX_DATA_HI) ? {8'h00, data_reg[15:8]} :
        (idx == `LPA_IDX_THLO_LO) ? {8'h00, thlo_reg[7:0]} :
        (idx == `LPA_IDX_THLO_HI) ? {8'h00, thlo_reg[15:8]} :
        (idx == `LPA_IDX_THHI_LO) ? {8'h00, thhi_reg[7:0]} :
        (idx == `LPA_IDX_THHI_HI) ? {8'h00, thhi_reg[15:8]} :
        (idx == `LPA_IDX_OSC)     ? OSC_KHZ :
        (idx == `LPA_IDX_STATUS)  ? {8'h00, status} :
                                    16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= rd_acc ? {16'h0000, rd_val} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl1_reg <= `LPA_CTRL1_RST;
            cfg_reg   <= `LPA_CTRL2_RST;
            thlo_reg  <= `LPA_THLO_RST;
            thhi_reg  <= `LPA_THHI_RST;
        end else begin
            if (wr_c1) begin
                ctrl1_reg <= wbyte;
            end
            if (wr_c2) begin
                cfg_reg <= wbyte;
            end
            if (wr_tll) begin
                thlo_reg[7:0] <= wbyte;
            end
            if (wr_tlh) begin
                thlo_reg[15:8] <= wbyte;
            end
            if (wr_thl) begin
                thhi_reg[7:0] <= wbyte;
            end
            if (wr_thh) begin
                thhi_reg[15:8] <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            led_current_sel <= 2'h0;
            adc_res_sel     <= 2'h0;
            range_sel       <= 2'h0;
        end else begin
            led_current_sel <= cfg_reg.current;
            adc_res_sel     <= cfg_reg.res;
            range_sel       <= cfg_reg.range;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result crossing from the oscillator domain
    wire new_res = tgl_sync[2] ^ tgl_sync[1];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tgl_sync    <= 3'h0;
            cap_vld_reg <= 1'b0;
            cap_reg     <= '0;
        end else begin
            tgl_sync    <= {tgl_sync[1:0], seq_tgl};
            cap_vld_reg <= new_res;
            if (new_res) begin
                cap_reg <= seq_result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // proximity scheme and source select
    // on-chip background subtraction
    wire [16:0] prox_diff = {1'b0, cap_reg.prox} - {1'b0, cap_reg.ir};
    wire [15:0] prox_val  = cfg_reg.scheme ? prox_diff[16:1] : cap_reg.prox;
    wire [1:0]  src       = ctrl1_reg[`LPA_C1_SRC_HI:`LPA_C1_SRC_LO];
    wire [15:0] sel_val   = (src == 2'h0) ? cap_reg.vis :
                            (src == 2'h1) ? cap_reg.ir : prox_val;

    ////////////////////////////////////////////////////////////////////////
    // alert window, persistence and flag
    // window compare
    wire       oow       = (sel_val < thlo_reg) || (sel_val > thhi_reg);
    wire [4:0] need      = pers_need(ctrl1_reg[`LPA_C1_PERS_HI:`LPA_C1_PERS_LO]);
    wire       host_clr  = rd_c1 || (wr_c1 && !wbyte[`LPA_C1_FLAG]);
    wire       host_set  = wr_c1 && wbyte[`LPA_C1_FLAG];
    wire       alert_set = cap_vld_reg && armed_reg && oow && (pcnt_next >= need);

    assign pcnt_next = !oow ? 5'h00 :
                       (pcnt_reg == 5'h1f) ? pcnt_reg : pcnt_reg + 5'h01;

    // hardware set wins over host clear
    assign flag_next = alert_set ? 1'b1 :
                       host_clr  ? 1'b0 :
                       host_set  ? 1'b1 : flag_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            armed_reg <= 1'b0;
        end else if (wr_c1 && !wbyte[`LPA_C1_FLAG]) begin
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            data_reg <= 16'h0000;
            pcnt_reg <= 5'h00;
        end else if (cap_vld_reg) begin
            data_reg <= sel_val;
            pcnt_reg <= pcnt_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag_reg <= 1'b0;
            int_n    <= 1'b1;
        end else begin
            flag_reg <= flag_next;
            int_n    <= ~flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase sequencer and led drive
    lpa_phase_seq u_seq (
        .osc_clk   (osc_clk),
        .sys_rst   (sys_rst),
        .run       (ctrl1_reg[`LPA_C1_RUN]),
        .res       (cfg_reg.res),
        .adc_count (adc_count),
        .phase     (conv_phase),
        .result    (seq_result),
        .done_tgl  (seq_tgl)
    );

    lpa_led_drive u_led (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .prox_phase (conv_phase == lpa_pkg::LPA_PH_PROX),
        .modulate   (cfg_reg.modulate),
        .led_on     (led_drive_output)
    );

endmodule : lpa_top

// ### verification/lpa_top_props.sv
module lpa_top_props (
    input wire logic           clk_sys,          // system clock
    input wire logic           sys_rst,          // sync reset
    input wire logic           osc_clk,          // osc clock
    input wire logic           wb_cyc_i,         // cycle
    input wire logic           wb_stb_i,         // strobe
    input wire logic           wb_we_i,          // write
    input wire logic [7:0]     wb_adr_i,         // address
    input wire logic [3:0]     wb_sel_i,         // select
    input wire logic [31:0]    wb_dat_i,         // write data
    input wire logic [31:0]    wb_dat_o,         // read data
    input wire logic           wb_ack_o,         // ack
    input lpa_pkg::lpa_phase_t conv_phase,       // phase
    input wire logic           led_drive_output, // led enable
    input wire logic [1:0]     led_current_sel,  // led current
    input wire logic           int_n             // alert pin
);
    wire        take     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wr_ctl2  = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h04;
    wire        acc_ctl1 = take && wb_adr_i == 8'h00;
    wire        in_prox  = conv_phase == lpa_pkg::LPA_PH_PROX;
    logic       mod_reg;
    logic [9:0] high_reg;
    ////////////////////////////////////////
    // modulate copy and led high run length
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mod_reg  <= 1'b0;
            high_reg <= 10'h000;
        end else begin
            if (wr_ctl2) begin
                mod_reg <= wb_dat_i[6];
            end
            high_reg <= led_drive_output ? high_reg + 10'h001 : 10'h000;
        end
    end
    ////////////////////////////////////////
    property p_ack_pulse;
        @(posedge clk_sys) disable iff (sys_rst) take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");
    property p_phase_order;
        @(posedge osc_clk) disable iff (sys_rst) $changed(conv_phase) |->
            conv_phase == lpa_pkg::LPA_PH_IDLE || 2'(conv_phase) == 2'($past(conv_phase)) + 2'h1;
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase out of order");
    property p_led_rise;
        @(posedge clk_sys) disable iff (sys_rst) $rose(led_drive_output) |-> in_prox;
    endproperty
    a_led_rise: assert property (p_led_rise) else $error("led on outside proximity");
    property p_led_off;
        @(posedge clk_sys) disable iff (sys_rst) (!in_prox) [*6] |-> !led_drive_output;
    endproperty
    a_led_off: assert property (p_led_off) else $error("led left on");
    property p_steady;
        @(posedge clk_sys) disable iff (sys_rst) $fell(led_drive_output) && !mod_reg |-> !in_prox;
    endproperty
    a_steady: assert property (p_steady) else $error("steady drive dropped");
    property p_square;
        @(posedge clk_sys) disable iff (sys_rst)
            $fell(led_drive_output) && mod_reg && in_prox |-> high_reg == 10'h15b;
    endproperty
    a_square: assert property (p_square) else $error("bad square half period");
    property p_cur_copy;
        @(posedge clk_sys) disable iff (sys_rst) wr_ctl2 |-> ##3 led_current_sel == $past(wb_dat_i[5:4], 3);
    endproperty
    a_cur_copy: assert property (p_cur_copy) else $error("current select wrong");
    property p_rd_clear;
        @(posedge clk_sys) disable iff (sys_rst) acc_ctl1 && !wb_we_i |-> ##2 int_n;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read left pin low");
    property p_int_rise;
        @(posedge clk_sys) disable iff (sys_rst) $rose(int_n) |-> $past(acc_ctl1) || $past(acc_ctl1, 2);
    endproperty
    a_int_rise: assert property (p_int_rise) else $error("pin released uncommanded");
endmodule : lpa_top_props

bind lpa_top lpa_top_props u_props (
    .clk_sys, .sys_rst, .osc_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .conv_phase, .led_drive_output, .led_current_sel, .int_n
);

// ### verification/lpa_front_model.sv
module lpa_front_model (
    output logic                osc_clk,    // oscillator clock
    input  lpa_pkg::lpa_phase_t conv_phase, // phase in progress
    input  wire logic [15:0]    vis_v,      // visible count
    input  wire logic [15:0]    ir_v,       // infrared count
    input  wire logic [15:0]    prox_v,     // proximity count
    output logic [15:0]         adc_count   // count to device
);
    timeunit 1ns;
    timeprecision 1ps;
    // free running, offset from system clock
    initial begin
        osc_clk = 1'b0;
        #7;
        forever begin
            #80 osc_clk = ~osc_clk;
        end
    end
    ////////////////////////////////////////
    // one count per phase
    always_comb begin
        case (conv_phase)
            lpa_pkg::LPA_PH_VIS:  adc_count = vis_v;
            lpa_pkg::LPA_PH_IR:   adc_count = ir_v;
            lpa_pkg::LPA_PH_PROX: adc_count = prox_v;
            default:              adc_count = ~prox_v;
        endcase
    end
endmodule : lpa_front_model

// ### verification/lpa_top_tb.sv
`include "lpa_consts.svh"

module lpa_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REXT = 2495;
    localparam int HALF = `LPA_CLK_HZ / (2 * `LPA_MOD_HZ);
    logic                clk_sys  = 1'b0;
    logic                sys_rst  = 1'b1;
    logic                osc_clk;
    logic [15:0]         adc_count;
    logic                wb_cyc_i = 1'b0;
    logic                wb_stb_i = 1'b0;
    logic                wb_we_i  = 1'b0;
    logic [7:0]          wb_adr_i = 8'h00;
    logic [3:0]          wb_sel_i = 4'h0;
    logic [31:0]         wb_dat_i = 32'h0;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o;
    lpa_pkg::lpa_phase_t conv_phase;
    logic                led_drive_output;
    logic [1:0]          led_current_sel;
    logic [1:0]          adc_res_sel;
    logic [1:0]          range_sel;
    logic                int_n;
    logic [15:0]         vis_v    = 16'h0;
    logic [15:0]         ir_v     = 16'h0;
    logic [15:0]         prox_v   = 16'h0;
    logic [31:0]         rd;
    logic [15:0]         exp_v;
    int                  failures    = 0;
    int                  comparisons = 0;
    int                  cycles      = 0;
    int                  n;

    lpa_top #(.REXT_KOHM(REXT)) dut (.clk_sys, .sys_rst, .osc_clk, .adc_count, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_phase, .led_drive_output, .led_current_sel,
        .adc_res_sel, .range_sel, .int_n);
    lpa_front_model u_front (.osc_clk, .conv_phase, .vis_v, .ir_v, .prox_v, .adc_count);

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 150000) begin
            failures = failures + 1;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end
    ////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] wd, output logic [31:0] q);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {2'b00, idx, 2'b00};
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, wd};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    // waits for fresh results through the status toggle
    task automatic wait_data(input int cnt);
        logic [31:0] s0;
        logic [31:0] s1;
        repeat (cnt) begin
            wb(1'b0, 4'ha, 8'h00, s0);
            do wb(1'b0, 4'ha, 8'h00, s1); while (s1[6] === s0[6]);
        end
    endtask : wait_data

    task automatic span(ref logic s, input logic lvl, output int len);
        len = 0;
        while (s === lvl) begin
            @(posedge clk_sys);
            len++;
        end
    endtask : span

    function automatic logic [31:0] exp_rst(input int i);
        case (i)
            6, 7: return 32'h0000_00ff;
            9: return 32'(`LPA_OSC_REF_KHZ * `LPA_REXT_REF_KOHM / REXT);
            default: return 32'h0;
        endcase
    endfunction : exp_rst
    ////////////////////////////////////////
    initial begin
        void'($urandom(68));
        repeat (200) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wb(1'b1, 4'hc, 8'ha5, rd);
        wb(1'b1, 4'h8, 8'h5a, rd);
        for (int i = 4; i < 13; i++) begin
            if (i != 10 && i != 11) begin
                wb(1'b0, 4'(i), 8'h00, rd);
                chk(rd, exp_rst(i), "reset value");
            end
        end
        for (int c = 0; c < 4; c++) begin
            exp_v = 16'($urandom());
            exp_v[5:4] = 2'(c);
            wb(1'b1, 4'h1, exp_v[7:0], rd);
            wb(1'b0, 4'h1, 8'h00, rd);
            chk(rd, {24'h0, exp_v[7:0]}, "ctrl2 readback");
            chk({26'h0, led_current_sel, adc_res_sel, range_sel}, {26'h0, exp_v[5:0]}, "selects");
        end
        for (int k = 0; k < 4; k++) begin
            vis_v  <= 16'($urandom_range(15));
            ir_v   <= 16'($urandom_range(15));
            prox_v <= 16'($urandom_range(15));
            wb(1'b1, 4'h1, (k == 3) ? 8'h8c : 8'h0c, rd);
            wb(1'b1, 4'h0, (k == 3) ? 8'hc0 : 8'(8'h80 | (k << 5)), rd);
            wait_data(2);
            exp_v = (k == 0) ? vis_v : (k == 1) ? ir_v : (k == 2) ? prox_v : 16'($signed(prox_v - ir_v) >>> 1);
            wb(1'b0, 4'h2, 8'h00, rd);
            chk(rd, {24'h0, exp_v[7:0]}, "data low");
            wb(1'b0, 4'h3, 8'h00, rd);
            chk(rd, {24'h0, exp_v[15:8]}, "data high");
        end
        vis_v <= 16'($urandom_range(11, 4));
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, 4'h4, 8'h00, rd);
            wb(1'b1, 4'h6, 8'hff, rd);
            wb(1'b1, 4'h7, 8'hff, rd);
            wb(1'b1, 4'h0, 8'(8'h80 | p), rd);
            wait_data(1);
            if (p[0]) begin
                wb(1'b1, 4'h7, 8'h00, rd);
                wb(1'b1, 4'h6, 8'(vis_v - 16'h1), rd);
            end else begin
                wb(1'b1, 4'h4, 8'(vis_v + 16'h1), rd);
            end
            span(int_n, 1'b1, n);
            wb(1'b0, 4'ha, 8'h00, rd);
            chk({27'h0, rd[5:1]}, 32'(p == 0 ? 1 : 2 << p), "run length");
            wb(1'b0, 4'h0, 8'h00, rd);
            chk({31'h0, rd[2]}, 32'h1, "flag bit");
            @(posedge clk_sys);
            chk({31'h0, int_n}, 32'h1, "pin released");
        end
        wb(1'b1, 4'h0, 8'h00, rd);
        // let any running conversion drain first
        repeat (2400) @(posedge clk_sys);
        wb(1'b1, 4'h1, 8'h0c, rd);
        wb(1'b1, 4'h0, 8'hc0, rd);
        span(led_drive_output, 1'b0, n);
        chk({30'h0, conv_phase}, {30'h0, lpa_pkg::LPA_PH_PROX}, "led phase");
        span(led_drive_output, 1'b1, n);
        chk(32'(n > 630 && n < 650), 32'h1, "steady span");
        wb(1'b1, 4'h0, 8'h00, rd);
        repeat (2400) @(posedge clk_sys);
        wb(1'b1, 4'h1, 8'h48, rd);
        wb(1'b1, 4'h0, 8'hc0, rd);
        span(led_drive_output, 1'b0, n);
        span(led_drive_output, 1'b1, n);
        chk(n, HALF, "high half");
        span(led_drive_output, 1'b0, n);
        chk(n, HALF, "low half");
        end_of_test();
    end
endmodule : lpa_top_tb
